// >>> hdl/dldc_consts.svh
/*
  register offsets, reset values, field positions and bus codes of the
  dual led dimming command register bank.
  assumes nothing; definitions only.
*/
`ifndef DLDC_CONSTS_SVH
`define DLDC_CONSTS_SVH
`define DLDC_IDX_CTRL     4'h1
`define DLDC_IDX_CH1_LOW  4'h2
`define DLDC_IDX_CH1_HIGH 4'h3
`define DLDC_IDX_CH2_LOW  4'h4
`define DLDC_IDX_CH2_HIGH 4'h5
`define DLDC_IDX_CH1_LVL  4'h6
`define DLDC_IDX_CH2_LVL  4'h7
`define DLDC_IDX_MASK     4'h8
`define DLDC_IDX_FLAGS    4'h9
`define DLDC_RST_CTRL     8'h0c
`define DLDC_RST_ZERO     8'h00
`define DLDC_RST_ONES     8'hff
`define DLDC_CTRL_WMASK   8'hcd
`define DLDC_BIT_LATCHOFF 7
`define DLDC_BIT_CLKOUT   6
`define DLDC_BIT_CH1_DIM  3
`define DLDC_BIT_CH2_DIM  2
`define DLDC_BIT_PHASE    0
`define DLDC_SCALE_HI     7
`define DLDC_SCALE_LO     5
`define DLDC_ONT_LO_HI    4
`define DLDC_BCAST_WR     8'h18
`define DLDC_BCAST_RD     8'h19
`define DLDC_DEV_PREFIX   3'h6
`define DLDC_BYTE_BITS    4'h8
`endif

// >>> hdl/dldc_pkg.sv
/*
  types of the dual led dimming command register bank.
  assumes dldc_consts.svh for the numbers themselves.
*/
package dldc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} dldc_st_t;
  typedef struct packed {
    logic            scl_s1;
    logic            scl_s2;
    logic            scl_s3;
    logic            sda_s1;
    logic            sda_s2;
    logic            sda_s3;
    logic [3:0]      adr_s1;
    logic [3:0]      adr_s2;
    dldc_st_t        st;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic [1:0]      byte_idx;
    logic            rd;
    logic            ara;
    logic            bcw;
    logic [7:0]      ptr;
    logic [9:0][7:0] hold;
    logic [9:0][7:0] work;
    logic            sda_oe;
    logic            alert;
    logic            restart;
  } dldc_state_t;
endpackage

// >>> hdl/dldc_regs.sv
/*
  i2c subordinate command and status register bank of a dual led driver,
  with broadcast counter restart and alert response.
  assumes scl/sda/address select levels arrive asynchronously, fault events
  come from logic on mclk, and the pwm and analog stages consume the outputs.
*/
// Contract
// - broadcast write byte 0x18 restarts both channel dimming counters together
// - broadcast write changes no register bit, only restarts counters
// - broadcast read: controller sends 0x19, alerting device answers one byte
// - answer byte is 110, four address bits, then zero
// - control bit 7 enables latch-off mode
// - control bit 6 enables the clock output
// - control bits 3 and 2 enable pulse dimming per channel, else always on
// - control bit 0 set shifts channel 2 dimming by half a period
// - first dimming register: scale in bits 7..5, low on-time bits 4..0
// - second dimming register: high eight on-time bits, both reset zero
// - analog level register per channel, msb first, resets to all ones
// - report mask enables each fault per channel, resets all enabled
// - fault flags show each reported fault, same layout, reset zero
// - written bytes wait in holding latches until a stop arrives
// - register pointer kept for reads until a new sub-address is written
// - alert answer aborts when driving one but seeing zero, retries later
// - after a full alert answer, release alert and ignore further requests
`include "dldc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dldc_regs #(
  parameter int NUM_REGS = 9
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [3:0] addr_sel,
  input  wire logic [7:0] fault_event,
  output logic            alert_out,
  output logic            alert_oe,
  output logic            dim_restart,
  output logic            latchoff_en,
  output logic            clkout_en,
  output logic            ch1_pulse_en,
  output logic            ch2_pulse_en,
  output logic            phase_shift,
  output logic [2:0]      ch1_freq_scale,
  output logic [12:0]     ch1_ontime,
  output logic [2:0]      ch2_freq_scale,
  output logic [12:0]     ch2_ontime,
  output logic [7:0]      ch1_level,
  output logic [7:0]      ch2_level,
  output logic [7:0]      fault_report_mask,
  output logic [7:0]      fault_flags
);
  import dldc_pkg::*;

  if (NUM_REGS != 9) begin : g_bad_regs
    $error("dldc_regs serves exactly nine registers");
  end

  dldc_state_t s_r;
  dldc_state_t s_nxt;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        ack;
  logic        flag_clr;
  logic [7:0]  fset;
  logic [7:0]  txbyte;

  function automatic logic is_rw(input logic [7:0] p);
    return (p[7:4] == 4'h0) && (p[3:0] >= `DLDC_IDX_CTRL) && (p[3:0] <= `DLDC_IDX_MASK);
  endfunction

  function automatic logic [7:0] rd_sel(input logic [7:0] p,
                                        input logic [9:0][7:0] h,
                                        input logic [7:0] flags);
    logic [7:0] v;
    v = 8'h00;
    if (is_rw(p)) begin
      v = h[p[3:0]];
    end else if (p == {4'h0, `DLDC_IDX_FLAGS}) begin
      v = flags;
    end
    return v;
  endfunction

  // edge detection reads only the second and third stages
  assign scl_rise = s_r.scl_s2 & ~s_r.scl_s3;
  assign scl_fall = ~s_r.scl_s2 & s_r.scl_s3;
  assign start_ev = s_r.scl_s2 & s_r.scl_s3 & ~s_r.sda_s2 & s_r.sda_s3;
  assign stop_ev  = s_r.scl_s2 & s_r.scl_s3 & s_r.sda_s2 & ~s_r.sda_s3;
  assign fset     = fault_event & s_r.work[`DLDC_IDX_MASK];
  // pending edits are visible on readback before the stop commits them
  assign txbyte   = s_r.ara ? {`DLDC_DEV_PREFIX, s_r.adr_s2, 1'b0}
                            : rd_sel(s_r.ptr, s_r.hold, s_r.work[`DLDC_IDX_FLAGS]);

  always_comb begin
    s_nxt = s_r;
    ack = 1'b0;
    flag_clr = 1'b0;
    s_nxt.scl_s1 = scl_in;
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_s3 = s_r.scl_s2;
    s_nxt.sda_s1 = sda_in;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_s3 = s_r.sda_s2;
    s_nxt.adr_s1 = addr_sel;
    s_nxt.adr_s2 = s_r.adr_s1;
    s_nxt.restart = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
      end
      ST_RX: begin
        if (scl_rise) begin
          s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s2};
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end else if (scl_fall && s_r.bitcnt == `DLDC_BYTE_BITS) begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.byte_idx == 2'd0) begin
            s_nxt.rd = s_r.shreg[0];
            s_nxt.ara = 1'b0;
            s_nxt.bcw = 1'b0;
            if (s_r.shreg[7:1] == {`DLDC_DEV_PREFIX, s_r.adr_s2}) begin
              ack = 1'b1;
            end else if (s_r.shreg == `DLDC_BCAST_WR) begin
              ack = 1'b1;
              s_nxt.bcw = 1'b1;
              s_nxt.restart = 1'b1;
            end else if (s_r.shreg == `DLDC_BCAST_RD && s_r.alert) begin
              ack = 1'b1;
              s_nxt.ara = 1'b1;
            end
          end else if (!s_r.bcw) begin
            // bytes after a broadcast write are not acked and touch nothing
            ack = 1'b1;
            if (s_r.byte_idx == 2'd1) begin
              s_nxt.ptr = s_r.shreg;
            end else if (is_rw(s_r.ptr)) begin
              s_nxt.hold[s_r.ptr[3:0]] = (s_r.ptr[3:0] == `DLDC_IDX_CTRL) ?
                (s_r.shreg & `DLDC_CTRL_WMASK) : s_r.shreg;
            end
          end
          s_nxt.byte_idx = (s_r.byte_idx == 2'd2) ? 2'd2 : s_r.byte_idx + 2'd1;
          s_nxt.st = ack ? ST_ACK : ST_IDLE;
          s_nxt.sda_oe = ack;
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.rd) begin
            s_nxt.st = ST_TX;
            s_nxt.shreg = txbyte;
            s_nxt.sda_oe = ~txbyte[7];
            flag_clr = !s_r.ara && (s_r.ptr == {4'h0, `DLDC_IDX_FLAGS});
          end else begin
            s_nxt.st = ST_RX;
            s_nxt.sda_oe = 1'b0;
          end
        end
      end
      ST_TX: begin
        if (scl_rise) begin
          if (s_r.ara && !s_r.sda_oe && !s_r.sda_s2) begin
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end
        end else if (scl_fall) begin
          if (s_r.bitcnt == `DLDC_BYTE_BITS) begin
            s_nxt.st = ST_TXACK;
            s_nxt.sda_oe = 1'b0;
            if (s_r.ara) begin
              s_nxt.alert = 1'b0;
            end
          end else begin
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.sda_oe = ~s_r.shreg[6];
          end
        end
      end
      ST_TXACK: begin
        if (scl_fall) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // a fault that lands on the clearing read still sets its flag
    s_nxt.work[`DLDC_IDX_FLAGS] = (flag_clr ? 8'h00 : s_r.work[`DLDC_IDX_FLAGS]) | fset;
    if ((fset & ~s_r.work[`DLDC_IDX_FLAGS]) != 8'h00) begin
      s_nxt.alert = 1'b1;
    end
    if (start_ev) begin
      s_nxt.st = ST_RX;
      s_nxt.bitcnt = 4'h0;
      s_nxt.byte_idx = 2'd0;
      s_nxt.sda_oe = 1'b0;
    end
    if (stop_ev) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe = 1'b0;
      s_nxt.work[`DLDC_IDX_MASK:`DLDC_IDX_CTRL] =
        s_r.hold[`DLDC_IDX_MASK:`DLDC_IDX_CTRL];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.scl_s1 <= 1'b1;
      s_r.scl_s2 <= 1'b1;
      s_r.scl_s3 <= 1'b1;
      s_r.sda_s1 <= 1'b1;
      s_r.sda_s2 <= 1'b1;
      s_r.sda_s3 <= 1'b1;
      s_r.st <= ST_IDLE;
      s_r.hold[`DLDC_IDX_CTRL] <= `DLDC_RST_CTRL;
      s_r.work[`DLDC_IDX_CTRL] <= `DLDC_RST_CTRL;
      s_r.hold[`DLDC_IDX_CH1_LVL] <= `DLDC_RST_ONES;
      s_r.work[`DLDC_IDX_CH1_LVL] <= `DLDC_RST_ONES;
      s_r.hold[`DLDC_IDX_CH2_LVL] <= `DLDC_RST_ONES;
      s_r.work[`DLDC_IDX_CH2_LVL] <= `DLDC_RST_ONES;
      s_r.hold[`DLDC_IDX_MASK] <= `DLDC_RST_ONES;
      s_r.work[`DLDC_IDX_MASK] <= `DLDC_RST_ONES;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out           = 1'b0;
  assign sda_oe            = s_r.sda_oe;
  assign alert_out         = 1'b0;
  assign alert_oe          = s_r.alert;
  assign dim_restart       = s_r.restart;
  assign latchoff_en       = s_r.work[`DLDC_IDX_CTRL][`DLDC_BIT_LATCHOFF];
  assign clkout_en         = s_r.work[`DLDC_IDX_CTRL][`DLDC_BIT_CLKOUT];
  assign ch1_pulse_en      = s_r.work[`DLDC_IDX_CTRL][`DLDC_BIT_CH1_DIM];
  assign ch2_pulse_en      = s_r.work[`DLDC_IDX_CTRL][`DLDC_BIT_CH2_DIM];
  assign phase_shift       = s_r.work[`DLDC_IDX_CTRL][`DLDC_BIT_PHASE];
  assign ch1_freq_scale    = s_r.work[`DLDC_IDX_CH1_LOW][`DLDC_SCALE_HI:`DLDC_SCALE_LO];
  assign ch1_ontime        = {s_r.work[`DLDC_IDX_CH1_HIGH],
                              s_r.work[`DLDC_IDX_CH1_LOW][`DLDC_ONT_LO_HI:0]};
  assign ch2_freq_scale    = s_r.work[`DLDC_IDX_CH2_LOW][`DLDC_SCALE_HI:`DLDC_SCALE_LO];
  assign ch2_ontime        = {s_r.work[`DLDC_IDX_CH2_HIGH],
                              s_r.work[`DLDC_IDX_CH2_LOW][`DLDC_ONT_LO_HI:0]};
  assign ch1_level         = s_r.work[`DLDC_IDX_CH1_LVL];
  assign ch2_level         = s_r.work[`DLDC_IDX_CH2_LVL];
  assign fault_report_mask = s_r.work[`DLDC_IDX_MASK];
  assign fault_flags       = s_r.work[`DLDC_IDX_FLAGS];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_bcast_restart: assert property (
    (s_r.st == ST_RX && scl_fall && s_r.bitcnt == `DLDC_BYTE_BITS && s_r.byte_idx == 2'd0
     && s_r.shreg == `DLDC_BCAST_WR && !start_ev && !stop_ev) |=> dim_restart ##1 !dim_restart)
    else $error("broadcast write did not pulse the restart");
  chk_bcast_nowrite: assert property (
    (s_r.bcw && s_r.st != ST_IDLE) |=> s_r.hold == $past(s_r.hold))
    else $error("broadcast write changed a holding latch");
  chk_ara_answer: assert property (
    (s_r.st == ST_TX && s_r.ara && s_r.bitcnt == 4'h0 && $past(s_r.st) == ST_ACK)
    |-> s_r.shreg == {`DLDC_DEV_PREFIX, s_r.adr_s2, 1'b0})
    else $error("alert answer byte is wrong");
  chk_hold_stop: assert property (
    !stop_ev |=> s_r.work[8:1] == $past(s_r.work[8:1]))
    else $error("working register changed without a stop");
  chk_commit_stop: assert property (
    stop_ev |=> s_r.work[8:1] == $past(s_r.hold[8:1]))
    else $error("stop did not commit the holding latches");
  chk_ptr_kept: assert property (
    (s_r.st != ST_RX) |=> s_r.ptr == $past(s_r.ptr))
    else $error("pointer moved outside a sub-address byte");
  chk_ara_abort: assert property (
    (s_r.st == ST_TX && s_r.ara && scl_rise && !s_r.sda_oe && !s_r.sda_s2
     && !start_ev && !stop_ev) |=> s_r.st == ST_IDLE && !sda_oe)
    else $error("lost arbitration without abort");
  chk_alert_release: assert property (
    (s_r.st == ST_TX && s_r.ara && scl_fall && s_r.bitcnt == `DLDC_BYTE_BITS
     && fset == 8'h00) |=> !alert_oe)
    else $error("alert not released after answer");
  chk_flag_set: assert property (
    (fset != 8'h00) |=> ((fault_flags & $past(fset)) == $past(fset)) && alert_oe ||
                        ($past(fset & ~fault_flags) == 8'h00))
    else $error("reported fault did not set its flag");
  chk_ctrl_unused: assert property (
    (s_r.hold[`DLDC_IDX_CTRL] & ~`DLDC_CTRL_WMASK) == 8'h00 ##1
    (s_r.work[`DLDC_IDX_CTRL] & ~`DLDC_CTRL_WMASK) == 8'h00)
    else $error("unused control bit became set");
endmodule
`default_nettype wire

// >>> tb/dldc_i2c_main.sv
/*
  i2c main controller model that drives the register bank's bus pins.
  assumes pull-ups on scl and sda, so a released line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module dldc_i2c_main (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // quarter of the 160 ns bus clock, paced by the shared clock
  task automatic q();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // entered with scl low this is a repeated start
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // data only moves while scl is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    q();
    r   = sda_line;
    scl = 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // one byte in, then ack (last = 0) or nack
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
  self-checking bench of the dimming command register bank.
  assumes dldc_i2c_main as bus controller and pull-ups on both lines.
*/
`include "dldc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dldc_pkg::*;
  logic        mclk      = 1'b0;
  logic        resetn    = 1'b0;
  logic [3:0]  asel      = 4'h5;
  logic [7:0]  fev       = 8'h00;
  logic        rival_low = 1'b0;
  logic        scl, sda_low, sda_out, sda_oe, alert_out, alert_oe, dim_restart;
  logic        lat, clko, p1, p2, ph;
  logic [2:0]  s1, s2;
  logic [12:0] t1, t2;
  logic [7:0]  l1, l2, fmask, fflags, rd;
  logic [6:0]  dev;
  logic        ack;
  wire logic   sda_line;
  int          error_cnt    = 0;
  int          total_checks = 0;
  int          restarts     = 0;
  assign sda_line = ~(sda_low | sda_oe | rival_low);
  assign dev = {`DLDC_DEV_PREFIX, asel};
  always #10 mclk = ~mclk;
  always @(posedge mclk)
    if (dim_restart === 1'b1)
      restarts++;
  dldc_i2c_main m (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  dldc_regs #(.NUM_REGS(9)) dut (
    .mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(asel), .fault_event(fev), .alert_out(alert_out),
    .alert_oe(alert_oe), .dim_restart(dim_restart), .latchoff_en(lat), .clkout_en(clko),
    .ch1_pulse_en(p1), .ch2_pulse_en(p2), .phase_shift(ph), .ch1_freq_scale(s1),
    .ch1_ontime(t1), .ch2_freq_scale(s2), .ch2_ontime(t2), .ch1_level(l1), .ch2_level(l2),
    .fault_report_mask(fmask), .fault_flags(fflags));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic ptr(input logic [7:0] a);
    m.start();
    m.send({dev, 1'b0}, ack);
    check(ack, 1'b1);
    m.send(a, ack);
    check(ack, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ptr(a);
    m.send(d, ack);
    check(ack, 1'b1);
  endtask
  // read at whatever pointer is kept; caller decides on stop
  task automatic rdp();
    m.start();
    m.send({dev, 1'b1}, ack);
    m.recv(1'b1, rd);
  endtask
  // stop is seen two cycles late, registers move one after
  task automatic commit();
    m.stop();
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_reset();
    check({lat, clko, p1, p2, ph}, 5'h06);
    check({s1, t1, s2, t2}, 32'h0);
    check({l1, l2}, 16'hffff);
    check({fmask, fflags}, 16'hff00);
    check({sda_out, sda_oe, alert_out, alert_oe, dim_restart}, 5'h00);
  endtask
  task automatic t_ctrl();
    wr(`DLDC_IDX_CTRL, 8'hff);
    rdp();
    check(rd, 8'hff & `DLDC_CTRL_WMASK);
    check(lat, 1'b0);
    commit();
    check({lat, clko, p1, p2, ph}, 5'h1f);
    wr(`DLDC_IDX_CTRL, 8'h41);
    commit();
    check({lat, clko, p1, p2, ph}, 5'h09);
  endtask
  task automatic t_dim();
    logic [7:0] v [7] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h81, 8'h42, 8'h0f};
    for (int i = 0; i < 7; i++) begin
      wr(8'(i + 2), v[i]);
      commit();
    end
    check({s1, t1}, {3'h5, 8'h3c, 5'h05});
    check({s2, t2}, {3'h2, 8'hc3, 5'h1a});
    check({l1, l2}, 16'h8142);
    check(fmask, 8'h0f);
    for (int i = 0; i < 2; i++) begin
      rdp();
      commit();
      check(rd, 8'h0f);
    end
  endtask
  task automatic t_bcast();
    restarts = 0;
    m.start();
    m.send(`DLDC_BCAST_WR, ack);
    check(ack, 1'b1);
    m.send(8'h00, ack);
    commit();
    check(16'(restarts), 16'h1);
    check({l1, l2, 3'h0, lat, clko, p1, p2, ph}, 24'h814209);
  endtask
  task automatic ara(input logic rival);
    m.start();
    m.send(`DLDC_BCAST_RD, ack);
    rival_low = rival;
    m.recv(1'b1, rd);
    rival_low = 1'b0;
    m.stop();
  endtask
  task automatic t_alert();
    int n;
    fev = 8'h02;
    @(posedge mclk);
    #1;
    fev = 8'h00;
    repeat (4) @(posedge mclk);
    check({alert_oe, fflags}, 9'h102);
    // a rival pulls sda low through the whole answer byte
    ara(1'b1);
    check({ack, alert_oe, sda_oe}, 3'h6);
    ara(1'b0);
    check(rd, {`DLDC_DEV_PREFIX, asel, 1'b0});
    n = 0;
    while (alert_oe !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      give_verdict();
    end
    m.start();
    m.send(`DLDC_BCAST_RD, ack);
    m.stop();
    check(ack, 1'b0);
    ptr(`DLDC_IDX_FLAGS);
    rdp();
    commit();
    check(rd, 8'h02);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_ctrl();
    t_dim();
    t_bcast();
    t_alert();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
